// ---- bench/crs_exec_tb.sv ----
// Self-checking bench for the call and return executor
`timescale 1ns/1ns
`default_nettype none

module crs_exec_tb
  import crs_pkg::*;
;
  typedef struct packed {
    logic [15:0] op;
    logic [20:0] pc;
    logic [20:0] top;
    logic [7:0]  w;
    logic        fl;
  } crs_row_s;

  // Start at address 2: one idle fetch runs before the first row
  localparam crs_row_s ROWS [8] = '{
    '{16'hd805, 21'h00000e, 21'h000004, 8'h00, 1'b1},
    '{16'hdc00, 21'h1ff810, 21'h000010, 8'h00, 1'b1},
    '{16'hdbff, 21'h000010, 21'h1ff812, 8'h00, 1'b1},
    '{16'h0ca5, 21'h1ff812, 21'h000010, 8'ha5, 1'b1},
    '{16'h0000, 21'h1ff814, 21'h000010, 8'ha5, 1'b0},
    '{16'h0cff, 21'h000010, 21'h000004, 8'hff, 1'b1},
    '{16'h0c00, 21'h000004, 21'h000000, 8'h00, 1'b1},
    '{16'h0c3c, 21'h000000, 21'h000000, 8'h3c, 1'b1}
  };

  logic        clk_i;
  logic        rst_i;
  logic [15:0] instr_i;
  logic [20:0] pc_o;
  logic [1:0]  phase_o;
  logic        flush_o;
  logic        soft_reset_o;
  logic [20:0] stack_top_o;
  crs_core_s   core_o;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [31:0] rd;
  logic        sr;
  int          checks;
  int          n_errors;
  int          cycles;

  crs_exec #(.PC_W(21), .DEPTH(31)) dut_u (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .instr_i      (instr_i),
    .pc_o         (pc_o),
    .phase_o      (phase_o),
    .flush_o      (flush_o),
    .soft_reset_o (soft_reset_o),
    .stack_top_o  (stack_top_o),
    .core_o       (core_o),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_we_i      (wb_we_i),
    .wb_adr_i     (wb_adr_i),
    .wb_sel_i     (wb_sel_i),
    .wb_dat_i     (wb_dat_i),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o)
  );

  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  // Waiting is bounded by the global cycle ceiling
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // Word placed at a Q4 edge so the next Q1 takes it; idle word after
  task automatic exec(input logic [15:0] op, input int edges);
    do @(negedge clk_i); while (phase_o !== 2'h3);
    @(posedge clk_i);
    instr_i <= op;
    @(posedge clk_i);
    instr_i <= 16'h0000;
    repeat (edges - 1) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic core_chk(input logic [20:0] pc, input logic [20:0] top);
    check("pc", 32'(pc_o), 32'(pc));
    check("top", 32'(stack_top_o), 32'(top));
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    rst_i    = 1'b1;
    instr_i  = 16'h0000;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    checks   = 0;
    n_errors = 0;
    cycles   = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check("core", 32'(core_o), 32'h0);
    foreach (ROWS[i]) begin
      exec(ROWS[i].op, 4);
      core_chk(ROWS[i].pc, ROWS[i].top);
      check("w", 32'(core_o.w), 32'(ROWS[i].w));
      check("flush", 32'(flush_o), 32'(ROWS[i].fl));
    end
    // Flush cycle must not advance the counter
    exec(16'h0000, 4);
    check("pc", 32'(pc_o), 32'h2);
    // Freeze taken at a phase-four edge, so the next fetch sees the written counter
    do @(negedge clk_i); while (phase_o !== 2'h2);
    wb(1'b1, 8'h00, 32'h0, rd);
    wb(1'b1, 8'h10, 32'h0009_5ac3, rd);
    wb(1'b1, 8'h1c, 32'h0000_1a3b, rd);
    wb(1'b1, 8'h04, 32'h11, rd);
    wb(1'b1, 8'h08, 32'h22, rd);
    wb(1'b1, 8'h0c, 32'h3, rd);
    wb(1'b1, 8'h14, 32'h100, rd);
    wb(1'b0, 8'h24, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    wb(1'b0, 8'h04, 32'h0, rd);
    check("w reg", rd, 32'h11);
    wb(1'b0, 8'h14, 32'h0, rd);
    check("pc reg", rd, 32'h100);
    wb(1'b1, 8'h00, 32'h1, rd);
    exec(16'hd810, 4);
    core_chk(21'h124, 21'h104);
    exec(16'h0010, 4);
    core_chk(21'h104, 21'h0);
    check("hi en", 32'(core_o.high_priority_global_enable), 32'h1);
    check("lo en", 32'(core_o.low_priority_global_enable), 32'h0);
    check("regs", {8'h00, core_o.w, core_o.status, 4'h0, core_o.bank_select_register}, 32'h0011_2203);
    exec(16'hdffe, 4);
    core_chk(21'h102, 21'h106);
    // Priority mode with high enable already set selects the low enable
    wb(1'b1, 8'h00, 32'h83, rd);
    exec(16'h0011, 4);
    core_chk(21'h106, 21'h0);
    check("lo en", 32'(core_o.low_priority_global_enable), 32'h1);
    check("regs", {8'h00, core_o.w, core_o.status, 4'h0, core_o.bank_select_register}, 32'h00c3_5a09);
    exec(16'hd803, 4);
    core_chk(21'h10e, 21'h108);
    exec(16'h0c77, 4);
    core_chk(21'h108, 21'h0);
    check("w", 32'(core_o.w), 32'h77);
    check("status", 32'(core_o.status), 32'h5a);
    wb(1'b0, 8'h1c, 32'h0, rd);
    check("latch", rd, 32'h0000_1a3b);
    exec(16'h00ff, 2);
    sr = soft_reset_o;
    core_chk(21'h0, 21'h0);
    check("core", 32'(core_o), 32'h0);
    check("phase", 32'(phase_o), 32'h0);
    @(negedge clk_i);
    sr = sr | soft_reset_o;
    check("soft rst", 32'(sr), 32'h1);
    results();
  end
endmodule

`default_nettype wire

// ---- design/crs_exec.sv ----
// Executor for relative call, software reset, interrupt return and literal return
// How it works
// RULE1: opcode with top five bits 11011 is a call carrying an 11-bit signed offset.
// RULE2: call pushes its own address plus two before touching the program counter.
// RULE3: call loads program counter with address plus two plus twice signed offset.
// RULE4: call lasts two cycles: push in phase two, counter write in phase four.
// RULE5: reset opcode restores every reset-affected register in phase two, one cycle.
// RULE6: interrupt return pops the stack into the program counter in phase four.
// RULE7: interrupt return sets the high or the low global interrupt enable.
// RULE8: shadow flag set copies working, status, bank shadows back; clear leaves them.
// RULE9: interrupt return leaves both program counter latch registers untouched.
// RULE10: literal return loads working register with its byte, flags left alone.
// RULE11: literal return pops counter and writes working register in phase four.
// RULE12: literal return leaves the high program counter latch untouched.
// RULE13: two-cycle instructions drop the fetched word and run a no-op second cycle.
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "crs_map.svh"

module crs_exec
  import crs_pkg::*;
#(
  parameter int PC_W  = 21,
  parameter int DEPTH = 31
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic [15:0]     instr_i,
  output logic      [PC_W-1:0] pc_o,
  output logic      [1:0]      phase_o,
  output logic                 flush_o,
  output logic                 soft_reset_o,
  output logic      [PC_W-1:0] stack_top_o,
  output crs_core_s            core_o,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o
);

  localparam int SP_W = $clog2(DEPTH + 1);

  if (PC_W < 13 || PC_W > 24) begin : g_bad_pc
    $error("crs_exec: PC_W must lie in 13..24");
  end
  if (DEPTH < 1 || DEPTH > 255) begin : g_bad_depth
    $error("crs_exec: DEPTH must lie in 1..255");
  end

  localparam logic [PC_W-1:0] RET_STEP = PC_W'(2);
  localparam logic [SP_W-1:0] SP_FULL  = SP_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] stk;
    logic [SP_W-1:0]            sp;
    logic [PC_W-1:0]            pc;
    logic [PC_W-1:0]            ia;
    logic [15:0]                ir;
    logic [1:0]                 q;
    crs_cycle_e                 cyc;
    logic                       run;
    logic                       prio;
    logic                       hi_en;
    logic                       lo_en;
    logic [7:0]                 w;
    logic [7:0]                 status;
    logic [3:0]                 bank;
    logic [7:0]                 wsh;
    logic [7:0]                 ss;
    logic [3:0]                 bs;
    logic [7:0]                 lat_h;
    logic [4:0]                 lat_u;
    logic                       soft_rst;
    logic                       ack;
    logic [31:0]                rdat;
  } crs_state_s;

  crs_state_s s_r;
  crs_state_s s_nxt;

  logic [PC_W-1:0] top;
  logic [PC_W-1:0] ret_addr;
  logic [PC_W-1:0] call_target;
  logic            is_call;
  logic            is_reset;
  logic            is_iret;
  logic            is_lret;
  logic            req;
  logic            wr;
  logic [31:0]     rd_val;
  logic [31:0]     wv;

  assign top         = (s_r.sp != '0) ? s_r.stk[s_r.sp - 1'b1] : '0;
  assign ret_addr    = s_r.ia + RET_STEP;
  assign call_target = ret_addr + {{(PC_W-12){s_r.ir[10]}}, s_r.ir[10:0], 1'b0}; // RULE3
  assign is_call     = (s_r.ir[15:11] == `CRS_OP_REL_CALL); // RULE1
  assign is_reset    = (s_r.ir == `CRS_OP_RESET);
  assign is_iret     = (s_r.ir[15:1] == `CRS_OP_INT_RET);
  assign is_lret     = (s_r.ir[15:8] == `CRS_OP_LIT_RET);
  assign req         = wb_cyc_i & wb_stb_i;
  assign wr          = req & ~s_r.ack & wb_we_i;

  // Byte lanes not selected keep the register's present contents
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        v[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return v;
  endfunction

  always_comb begin
    rd_val = 32'h0000_0000;
    case (wb_adr_i)
      `CRS_ADR_CTRL: begin
        rd_val[`CRS_CTRL_RUN]   = s_r.run;
        rd_val[`CRS_CTRL_PRIO]  = s_r.prio;
        rd_val[`CRS_CTRL_LO_EN] = s_r.lo_en;
        rd_val[`CRS_CTRL_HI_EN] = s_r.hi_en;
      end
      `CRS_ADR_WREG:   rd_val[7:0] = s_r.w;
      `CRS_ADR_STATUS: rd_val[7:0] = s_r.status;
      `CRS_ADR_BANK:   rd_val[3:0] = s_r.bank;
      `CRS_ADR_SHADOW: rd_val[19:0] = {s_r.bs, s_r.ss, s_r.wsh};
      `CRS_ADR_PC:     rd_val[PC_W-1:0] = s_r.pc;
      `CRS_ADR_STACK: begin
        rd_val[PC_W-1:0]       = top;
        rd_val[24 +: SP_W]     = s_r.sp;
      end
      `CRS_ADR_LATCH:  rd_val[12:0] = {s_r.lat_u, s_r.lat_h};
      `CRS_ADR_STATE: begin
        rd_val[1:0]   = s_r.q;
        rd_val[2]     = (s_r.cyc == CRS_NOP);
        rd_val[31:16] = s_r.ir;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  assign wv = merge(rd_val, wb_dat_i, wb_sel_i);

  always_comb begin
    crs_state_s rst_v;
    rst_v        = '0;
    rst_v.run    = `CRS_RST_RUN;
    rst_v.prio   = `CRS_RST_PRIO;
    rst_v.hi_en  = `CRS_RST_HI_EN;
    rst_v.lo_en  = `CRS_RST_LO_EN;
    rst_v.w      = `CRS_RST_W;
    rst_v.status = `CRS_RST_STATUS;
    rst_v.bank   = `CRS_RST_BANK;
    rst_v.cyc    = CRS_EXEC;
    // Bus read data is not core state; a pending read keeps its answer
    rst_v.rdat   = s_r.rdat;
    s_nxt          = s_r;
    s_nxt.soft_rst = 1'b0;
    if (s_r.run) begin
      s_nxt.q = s_r.q + `CRS_Q_STEP;
      case (s_r.cyc)
        CRS_EXEC: begin
          case (s_r.q)
            `CRS_Q1: begin
              s_nxt.ir = instr_i;
              s_nxt.ia = s_r.pc;
            end
            `CRS_Q2: begin
              if (is_reset) begin
                // Phase counter restarts too, so the next cycle begins cleanly at phase one
                s_nxt          = rst_v; // RULE5
                s_nxt.soft_rst = 1'b1;
              end else if (is_call && s_r.sp != SP_FULL) begin
                // Overflow handling lives elsewhere; a full stack simply drops the push
                s_nxt.stk[s_r.sp] = ret_addr; // RULE2 RULE4
                s_nxt.sp          = s_r.sp + 1'b1;
              end
            end
            `CRS_Q4: begin
              if (is_call) begin
                s_nxt.pc  = call_target; // RULE3 RULE4
                s_nxt.cyc = CRS_NOP; // RULE13
              end else if (is_iret || is_lret) begin
                // Counter comes from the stack alone; latch registers stay as they are
                s_nxt.pc  = top; // RULE6 RULE9 RULE11 RULE12
                s_nxt.cyc = CRS_NOP; // RULE13
                if (s_r.sp != '0) begin
                  s_nxt.sp = s_r.sp - 1'b1;
                end
                if (is_lret) begin
                  s_nxt.w = s_r.ir[7:0]; // RULE10 RULE11
                end else begin
                  if (s_r.prio && s_r.hi_en) begin
                    s_nxt.lo_en = 1'b1; // RULE7
                  end else begin
                    s_nxt.hi_en = 1'b1; // RULE7
                  end
                  if (s_r.ir[0]) begin
                    s_nxt.w      = s_r.wsh; // RULE8
                    s_nxt.status = s_r.ss;
                    s_nxt.bank   = s_r.bs;
                  end
                end
              end else begin
                s_nxt.pc = ret_addr;
              end
            end
            default: ;
          endcase
        end
        CRS_NOP: begin
          // Word fetched under the old counter is never decoded
          if (s_r.q == `CRS_Q4) begin
            s_nxt.cyc = CRS_EXEC; // RULE13
          end
        end
        default: s_nxt.cyc = CRS_EXEC;
      endcase
    end
    // Bus access has the last word; a software write beats a same-cycle core update
    s_nxt.ack = req & ~s_r.ack;
    if (req && !s_r.ack) begin
      s_nxt.rdat = rd_val;
    end
    if (wr) begin
      case (wb_adr_i)
        `CRS_ADR_CTRL: begin
          s_nxt.run   = wv[`CRS_CTRL_RUN];
          s_nxt.prio  = wv[`CRS_CTRL_PRIO];
          s_nxt.lo_en = wv[`CRS_CTRL_LO_EN];
          s_nxt.hi_en = wv[`CRS_CTRL_HI_EN];
        end
        `CRS_ADR_WREG:   s_nxt.w = wv[7:0];
        `CRS_ADR_STATUS: s_nxt.status = wv[7:0];
        `CRS_ADR_BANK:   s_nxt.bank = wv[3:0];
        `CRS_ADR_SHADOW: begin
          s_nxt.wsh = wv[7:0];
          s_nxt.ss = wv[15:8];
          s_nxt.bs = wv[19:16];
        end
        `CRS_ADR_PC:     s_nxt.pc = wv[PC_W-1:0];
        `CRS_ADR_LATCH: begin
          s_nxt.lat_h = wv[7:0];
          s_nxt.lat_u = wv[12:8];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r        <= '0;
      s_r.run    <= `CRS_RST_RUN;
      s_r.prio   <= `CRS_RST_PRIO;
      s_r.hi_en  <= `CRS_RST_HI_EN;
      s_r.lo_en  <= `CRS_RST_LO_EN;
      s_r.w      <= `CRS_RST_W;
      s_r.status <= `CRS_RST_STATUS;
      s_r.bank   <= `CRS_RST_BANK;
      s_r.cyc    <= CRS_EXEC;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pc_o                               = s_r.pc;
  assign phase_o                            = s_r.q;
  assign flush_o                            = (s_r.cyc == CRS_NOP);
  assign soft_reset_o                       = s_r.soft_rst;
  assign stack_top_o                        = top;
  assign core_o.w                           = s_r.w;
  assign core_o.status                      = s_r.status;
  assign core_o.bank_select_register        = s_r.bank;
  assign core_o.high_priority_global_enable = s_r.hi_en;
  assign core_o.low_priority_global_enable  = s_r.lo_en;
  assign core_o.priority_mode               = s_r.prio;
  assign wb_dat_o                           = s_r.rdat;
  assign wb_ack_o                           = s_r.ack;

  logic ex_q2;
  logic ex_q4;
  assign ex_q2 = s_r.run && s_r.cyc == CRS_EXEC && s_r.q == `CRS_Q2 && !wr;
  assign ex_q4 = s_r.run && s_r.cyc == CRS_EXEC && s_r.q == `CRS_Q4 && !wr;

  call_push_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    ex_q2 && is_call && s_r.sp != SP_FULL |=> s_r.sp == $past(s_r.sp) + 1'b1 && top == $past(ret_addr))
    else $error("call did not push its return address");

  call_target_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    ex_q4 && is_call |=> s_r.pc == $past(s_r.ia) + RET_STEP
      + {{(PC_W-12){$past(s_r.ir[10])}}, $past(s_r.ir[10:0]), 1'b0})
    else $error("call target wrong");

  // Bus writes in the window are excluded, they may move the counter legally
  call_timing_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    ex_q2 && is_call ##1 !wr |=> $stable(s_r.pc) && $past(s_r.pc) == $past(s_r.pc, 2) && s_r.q == `CRS_Q4)
    else $error("call changed the counter before phase four");

  soft_reset_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    ex_q2 && is_reset |=> s_r.pc == '0 && s_r.sp == '0 && s_r.w == `CRS_RST_W && soft_reset_o && s_r.q == `CRS_Q1)
    else $error("software reset did not restore reset values");

  ret_pop_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    ex_q4 && (is_iret || is_lret) && s_r.sp != '0 |=> s_r.pc == $past(top) && s_r.sp == $past(s_r.sp) - 1'b1)
    else $error("return did not pop into the counter");

  // Priority mode with the high enable already on re-arms the low level only
  ret_enable_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    ex_q4 && is_iret |=> (($past(s_r.prio) && $past(s_r.hi_en)) ? (s_r.lo_en && s_r.hi_en)
      : (s_r.hi_en && s_r.lo_en == $past(s_r.lo_en))))
    else $error("interrupt return did not enable interrupts");

  shadow_copy_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    ex_q4 && is_iret |=> s_r.w == ($past(s_r.ir[0]) ? $past(s_r.wsh) : $past(s_r.w))
      && s_r.status == ($past(s_r.ir[0]) ? $past(s_r.ss) : $past(s_r.status))
      && s_r.bank == ($past(s_r.ir[0]) ? $past(s_r.bs) : $past(s_r.bank)))
    else $error("shadow restore wrong");

  latch_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    ex_q4 && is_iret |=> $stable(s_r.lat_u) && $stable(s_r.lat_h))
    else $error("interrupt return touched a latch register");

  literal_w_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    ex_q4 && is_lret |=> s_r.w == $past(s_r.ir[7:0]) && $stable(s_r.status))
    else $error("literal return wrote the wrong working value");

  literal_pop_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    ex_q4 && is_lret |=> s_r.pc == $past(top) && s_r.w == $past(s_r.ir[7:0]) && s_r.q == `CRS_Q1)
    else $error("literal return did not pop and load in phase four");

  literal_latch_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    ex_q4 && is_lret |=> $stable(s_r.lat_h))
    else $error("literal return touched the high latch");

  nop_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    ex_q4 && (is_call || is_iret || is_lret) && s_r.run |=> flush_o [*4] ##1 !flush_o)
    else $error("second cycle not a four-phase no-op");

endmodule

`default_nettype wire

// ---- design/crs_map.svh ----
// Offsets, field positions, opcodes and reset values of the call and return executor
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

// Register byte offsets
`define CRS_ADR_CTRL      8'h00
`define CRS_ADR_WREG      8'h04
`define CRS_ADR_STATUS    8'h08
`define CRS_ADR_BANK      8'h0c
`define CRS_ADR_SHADOW    8'h10
`define CRS_ADR_PC        8'h14
`define CRS_ADR_STACK     8'h18
`define CRS_ADR_LATCH     8'h1c
`define CRS_ADR_STATE     8'h20

// Control register fields
`define CRS_CTRL_RUN      0
`define CRS_CTRL_PRIO     1
`define CRS_CTRL_LO_EN    6
`define CRS_CTRL_HI_EN    7

// Opcode patterns
`define CRS_OP_REL_CALL   5'h1b
`define CRS_OP_RESET      16'h00ff
`define CRS_OP_INT_RET    15'h0008
`define CRS_OP_LIT_RET    8'h0c

// Quarter phases of one instruction cycle
`define CRS_Q1            2'h0
`define CRS_Q2            2'h1
`define CRS_Q3            2'h2
`define CRS_Q4            2'h3
`define CRS_Q_STEP        2'h1

// Reset values
`define CRS_RST_RUN       1'b1
`define CRS_RST_PRIO      1'b0
`define CRS_RST_HI_EN     1'b0
`define CRS_RST_LO_EN     1'b0
`define CRS_RST_W         8'h00
`define CRS_RST_STATUS    8'h00
`define CRS_RST_BANK      4'h0

`endif

// ---- design/crs_pkg.sv ----
// Types shared by the call and return executor
package crs_pkg;

  typedef enum logic [0:0] {
    CRS_EXEC,
    CRS_NOP
  } crs_cycle_e;

  // Live core registers handed to the rest of the core
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] status;
    logic [3:0] bank_select_register;
    logic       high_priority_global_enable;
    logic       low_priority_global_enable;
    logic       priority_mode;
  } crs_core_s;

endpackage
